/* File: common/tlc_map.svh */
// Purpose: Byte offsets, field positions and reset values of the tuning page
// Assumes: Byte addresses 128..255 of the upper page, one bank of 8 lanes
// Notes:   Definitions only
`ifndef TLC_MAP_SVH
`define TLC_MAP_SVH

`define TLC_LANES        8
`define TLC_GRID_BASE    8'h80
`define TLC_CHAN_BASE    8'h88
`define TLC_FINE_BASE    8'h98
`define TLC_FREQ_BASE    8'hA8
`define TLC_POWER_BASE   8'hC8
`define TLC_RSVA_BASE    8'hD8
`define TLC_STAT_BASE    8'hDE
`define TLC_SUMM_ADDR    8'hE6
`define TLC_FLAG_BASE    8'hE7
`define TLC_MASK_BASE    8'hEF
`define TLC_RSVB_BASE    8'hF7

`define TLC_GRID_MSB     7
`define TLC_GRID_LSB     4
`define TLC_FINE_EN_BIT  0
`define TLC_STAT_ACTIVE  1
`define TLC_STAT_UNLOCK  0

`define TLC_FLAG_DONE    0
`define TLC_FLAG_UNLOCK  1
`define TLC_FLAG_CHAN    2
`define TLC_FLAG_REFUSE  3
`define TLC_FLAG_FINE    4
`define TLC_FLAG_POWER   5
`define TLC_FLAG_USED    8'h3F
`define TLC_MASK_RESET   8'h3F
`define TLC_GRID_RESET   4'hF

`endif

/* File: common/tlc_pkg.sv */
// Purpose: Types shared by the tuning page and its laser-side logic
// Assumes: One bank of 8 media lanes
// Notes:   Numbers live in tlc_map.svh
package tlc_pkg;

  typedef struct packed {
    logic [3:0]  grid;
    logic        fine_en;
    logic [15:0] channel;
    logic [15:0] fine;
    logic [15:0] power;
  } tlc_lane_ctrl_type;

  typedef struct packed {
    logic [31:0] frequency;
    logic        active;
    logic        unlocked;
  } tlc_lane_stat_type;

  typedef struct packed {
    logic done;
    logic refused;
  } tlc_lane_evt_type;

endpackage

/* File: src/tlc_page.sv */
// Purpose: Per-lane tunable laser control and status register page
// Assumes: Byte-wide management port on clk_sys; laser logic on clk_sys
// Notes:   Read data is registered one cycle after the read strobe
`timescale 1ns/100ps
`include "tlc_map.svh"

module tlc_page
  import tlc_pkg::*;
#(
  parameter logic signed [15:0] CHAN_MIN  = -16'sd100,
  parameter logic signed [15:0] CHAN_MAX  = 16'sd100,
  parameter logic signed [15:0] FINE_MIN  = -16'sd5000,
  parameter logic signed [15:0] FINE_MAX  = 16'sd5000,
  parameter logic signed [15:0] POWER_MIN = -16'sd1000,
  parameter logic signed [15:0] POWER_MAX = 16'sd500
) (
  // Clock and reset
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  // Management byte port
  input  wire logic [7:0]                         reg_addr,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  input  wire logic [7:0]                         reg_wdata,
  output logic      [7:0]                         reg_rdata,
  output logic                                    reg_rvalid,
  // Laser side
  output tlc_lane_ctrl_type [`TLC_LANES-1:0]      lane_ctrl,
  input  wire tlc_lane_stat_type [`TLC_LANES-1:0] lane_stat,
  input  wire tlc_lane_evt_type [`TLC_LANES-1:0]  lane_evt,
  // Module level indications
  output logic                                    irq_req,
  output logic                                    page_present
);

  localparam int LANES = `TLC_LANES;

  tlc_lane_ctrl_type [LANES-1:0] ctrl;
  tlc_lane_ctrl_type [LANES-1:0] next_ctrl;
  logic [LANES-1:0][7:0]         flags;
  logic [LANES-1:0][7:0]         next_flags;
  logic [LANES-1:0][7:0]         masks;
  logic [LANES-1:0][7:0]         next_masks;
  logic [7:0]                    next_rdata;
  logic [LANES-1:0]              summary;

  // Address falls inside [base, base+size)
  function automatic logic in_area(input logic [7:0] addr,
                                   input logic [7:0] base,
                                   input logic [8:0] size);
    logic [8:0] top;
    top = {1'b0, base} + size;
    return ({1'b0, addr} >= {1'b0, base}) && ({1'b0, addr} < top);
  endfunction

  // Lane index of a byte in an array whose entries are 2**shift bytes
  function automatic logic [2:0] lane_of(input logic [7:0] addr,
                                         input logic [7:0] base,
                                         input logic [1:0] shift);
    logic [7:0] off;
    off = addr - base;
    return 3'(off >> shift);
  endfunction

  // Byte of a 16-bit word, high byte at the lower address
  function automatic logic [7:0] word_byte(input logic [15:0] w,
                                           input logic        lo);
    return lo ? w[7:0] : w[15:8];
  endfunction

  function automatic logic out_range(input logic signed [15:0] v,
                                     input logic signed [15:0] lo,
                                     input logic signed [15:0] hi);
    return (v < lo) || (v > hi);
  endfunction

  logic hit_grid;
  logic hit_chan;
  logic hit_fine;
  logic hit_freq;
  logic hit_power;
  logic hit_stat;
  logic hit_flag;
  logic hit_mask;
  logic byte_lo;

  assign hit_grid  = in_area(reg_addr, `TLC_GRID_BASE, 9'd8);
  assign hit_chan  = in_area(reg_addr, `TLC_CHAN_BASE, 9'd16);
  assign hit_fine  = in_area(reg_addr, `TLC_FINE_BASE, 9'd16);
  assign hit_freq  = in_area(reg_addr, `TLC_FREQ_BASE, 9'd32);
  assign hit_power = in_area(reg_addr, `TLC_POWER_BASE, 9'd16);
  assign hit_stat  = in_area(reg_addr, `TLC_STAT_BASE, 9'd8);
  assign hit_flag  = in_area(reg_addr, `TLC_FLAG_BASE, 9'd8);
  assign hit_mask  = in_area(reg_addr, `TLC_MASK_BASE, 9'd8);
  // Word arrays start on even addresses, so bit 0 picks the byte
  assign byte_lo   = reg_addr[0];

  // Control, flags and masks
  always_comb begin
    logic [7:0]         set_f;
    logic [7:0]         clr_f;
    logic signed [15:0] word;
    logic               grid_wr;
    logic               chan_ok;
    set_f      = '0;
    clr_f      = '0;
    word       = '0;
    grid_wr    = 1'b0;
    chan_ok    = 1'b0;
    next_ctrl  = ctrl;
    next_flags = flags;
    next_masks = masks;
    for (int l = 0; l < LANES; l++) begin
      set_f   = '0;
      clr_f   = '0;
      grid_wr = reg_wr && hit_grid &&
                lane_of(reg_addr, `TLC_GRID_BASE, 2'd0) == 3'(l);
      chan_ok = 1'b0;
      if (grid_wr) begin
        next_ctrl[l].grid    = reg_wdata[`TLC_GRID_MSB:`TLC_GRID_LSB];
        next_ctrl[l].fine_en = reg_wdata[`TLC_FINE_EN_BIT];
        chan_ok = 1'b1;
      end
      if (reg_wr && hit_chan &&
          lane_of(reg_addr, `TLC_CHAN_BASE, 2'd1) == 3'(l)) begin
        if (byte_lo) begin
          word = {ctrl[l].channel[15:8], reg_wdata};
          next_ctrl[l].channel[7:0] = reg_wdata;
          if (out_range(word, CHAN_MIN, CHAN_MAX)) begin
            set_f[`TLC_FLAG_CHAN] = 1'b1;
          end else begin
            chan_ok = 1'b1;
          end
        end else begin
          next_ctrl[l].channel[15:8] = reg_wdata;
        end
      end
      if (reg_wr && hit_fine &&
          lane_of(reg_addr, `TLC_FINE_BASE, 2'd1) == 3'(l)) begin
        if (byte_lo) begin
          word = {ctrl[l].fine[15:8], reg_wdata};
          next_ctrl[l].fine[7:0] = reg_wdata;
          set_f[`TLC_FLAG_FINE] = out_range(word, FINE_MIN,
                                            FINE_MAX);
        end else begin
          next_ctrl[l].fine[15:8] = reg_wdata;
        end
      end
      if (reg_wr && hit_power &&
          lane_of(reg_addr, `TLC_POWER_BASE, 2'd1) == 3'(l)) begin
        if (byte_lo) begin
          word = {ctrl[l].power[15:8], reg_wdata};
          next_ctrl[l].power[7:0] = reg_wdata;
          set_f[`TLC_FLAG_POWER] = out_range(word, POWER_MIN,
                                             POWER_MAX);
        end else begin
          next_ctrl[l].power[15:8] = reg_wdata;
        end
      end
      if (reg_wr && hit_mask &&
          lane_of(reg_addr, `TLC_MASK_BASE, 2'd0) == 3'(l)) begin
        next_masks[l] = reg_wdata & `TLC_FLAG_USED;
      end
      set_f[`TLC_FLAG_DONE]   = lane_evt[l].done;
      set_f[`TLC_FLAG_UNLOCK] = lane_stat[l].unlocked;
      set_f[`TLC_FLAG_REFUSE] = lane_evt[l].refused;
      // A clean reprogram drops the refusal; a new refusal wins
      if (chan_ok) begin
        clr_f[`TLC_FLAG_REFUSE] = 1'b1;
      end
      if (reg_rd && hit_flag &&
          lane_of(reg_addr, `TLC_FLAG_BASE, 2'd0) == 3'(l)) begin
        clr_f = 8'hFF;
      end
      next_flags[l] = ((flags[l] & ~clr_f) | set_f) & `TLC_FLAG_USED;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int l = 0; l < LANES; l++) begin
        ctrl[l].grid    <= `TLC_GRID_RESET;
        ctrl[l].fine_en <= 1'b0;
        ctrl[l].channel <= '0;
        ctrl[l].fine    <= '0;
        ctrl[l].power   <= '0;
        flags[l]        <= '0;
        masks[l]        <= `TLC_MASK_RESET;
      end
    end else begin
      ctrl  <= next_ctrl;
      flags <= next_flags;
      masks <= next_masks;
    end
  end

  // Read mux; reserved and unknown bytes read zero
  always_comb begin
    logic [2:0]  ln;
    logic [31:0] fq;
    ln = '0;
    fq = '0;
    next_rdata = '0;
    if (hit_grid) begin
      ln = lane_of(reg_addr, `TLC_GRID_BASE, 2'd0);
      next_rdata = {ctrl[ln].grid, 3'h0, ctrl[ln].fine_en};
    end else if (hit_chan) begin
      ln = lane_of(reg_addr, `TLC_CHAN_BASE, 2'd1);
      next_rdata = word_byte(ctrl[ln].channel, byte_lo);
    end else if (hit_fine) begin
      ln = lane_of(reg_addr, `TLC_FINE_BASE, 2'd1);
      next_rdata = word_byte(ctrl[ln].fine, byte_lo);
    end else if (hit_freq) begin
      ln = lane_of(reg_addr, `TLC_FREQ_BASE, 2'd2);
      fq = lane_stat[ln].frequency;
      case (reg_addr[1:0])
        2'h0:    next_rdata = fq[31:24];
        2'h1:    next_rdata = fq[23:16];
        2'h2:    next_rdata = fq[15:8];
        default: next_rdata = fq[7:0];
      endcase
    end else if (hit_power) begin
      ln = lane_of(reg_addr, `TLC_POWER_BASE, 2'd1);
      next_rdata = word_byte(ctrl[ln].power, byte_lo);
    end else if (hit_stat) begin
      ln = lane_of(reg_addr, `TLC_STAT_BASE, 2'd0);
      // Laser logic raises active for channel, fine and power moves
      next_rdata[`TLC_STAT_ACTIVE] = lane_stat[ln].active;
      next_rdata[`TLC_STAT_UNLOCK] = lane_stat[ln].unlocked;
    end else if (reg_addr == `TLC_SUMM_ADDR) begin
      next_rdata = summary;
    end else if (hit_flag) begin
      ln = lane_of(reg_addr, `TLC_FLAG_BASE, 2'd0);
      next_rdata = flags[ln];
    end else if (hit_mask) begin
      ln = lane_of(reg_addr, `TLC_MASK_BASE, 2'd0);
      next_rdata = masks[ln];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= '0;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata  <= reg_rd ? next_rdata : reg_rdata;
      reg_rvalid <= reg_rd;
    end
  end

  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      summary[l] = |flags[l];
    end
  end

  always_comb begin
    irq_req = 1'b0;
    for (int l = 0; l < LANES; l++) begin
      irq_req = irq_req | (|(flags[l] & ~masks[l]));
    end
  end

  // Fixed presence; the advertising page reads this strap
  assign page_present = 1'b1;
  assign lane_ctrl    = ctrl;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_read_flag0;
    reg_rd && reg_addr == `TLC_FLAG_BASE;
  endsequence

  a_flag_clear_read: assert property (
    s_read_flag0 and (!lane_evt[0].done && !lane_evt[0].refused &&
    !lane_stat[0].unlocked && !(reg_wr && hit_grid))
    |=> flags[0] == 8'h00 ##0 reg_rvalid)
    else $error("lane 1 flags not cleared by read");

  a_flag_hold: assert property (
    flags[0][`TLC_FLAG_DONE] && !(reg_rd && reg_addr == `TLC_FLAG_BASE)
    |=> flags[0][`TLC_FLAG_DONE])
    else $error("tuning done flag dropped without read");

  a_done_latch: assert property (
    lane_evt[1].done |=> flags[1][`TLC_FLAG_DONE])
    else $error("tuning done not latched");

  a_power_range: assert property (
    reg_wr && reg_addr == (`TLC_POWER_BASE + 8'h01) &&
    out_range({ctrl[0].power[15:8], reg_wdata}, POWER_MIN, POWER_MAX)
    |=> flags[0][`TLC_FLAG_POWER] && ctrl[0].power[7:0] == $past(reg_wdata))
    else $error("power target range flag missing");

  a_fine_range: assert property (
    reg_wr && reg_addr == (`TLC_FINE_BASE + 8'h01) &&
    out_range({ctrl[0].fine[15:8], reg_wdata}, FINE_MIN, FINE_MAX)
    |=> flags[0][`TLC_FLAG_FINE])
    else $error("fine offset range flag missing");

  a_chan_range: assert property (
    reg_wr && reg_addr == (`TLC_CHAN_BASE + 8'h01) &&
    out_range({ctrl[0].channel[15:8], reg_wdata}, CHAN_MIN, CHAN_MAX)
    |=> flags[0][`TLC_FLAG_CHAN])
    else $error("channel range flag missing");

  a_summary_read: assert property (
    reg_rd && reg_addr == `TLC_SUMM_ADDR
    |=> reg_rvalid && reg_rdata == $past(summary) &&
        (reg_rdata[0] == |$past(flags[0])))
    else $error("summary byte disagrees with flags");

  a_irq_unmasked: assert property (
    $rose(flags[1][`TLC_FLAG_DONE]) && !masks[1][`TLC_FLAG_DONE]
    |-> irq_req)
    else $error("unmasked flag raised no interrupt");

  a_rsvd_zero: assert property (
    reg_rd && reg_addr >= `TLC_RSVB_BASE |=> reg_rdata == 8'h00)
    else $error("reserved byte read nonzero");

  a_status_read: assert property (
    reg_rd && reg_addr == `TLC_STAT_BASE
    |=> reg_rdata == {6'h00, $past(lane_stat[0].active),
                      $past(lane_stat[0].unlocked)})
    else $error("status byte wrong");

endmodule

/* File: verification/tlc_laser_model.sv */
// Purpose: Behavioural laser side for the tuning page bench
// Assumes: Same clock as the page; bench commands unlock and refusal
// Notes:   Any channel, fine or power change starts a settle countdown
`timescale 1ns/100ps
`include "tlc_map.svh"
module tlc_laser_model
  import tlc_pkg::*;
#(
  parameter int SETTLE = 4
) (
  // Clock and reset
  input  wire logic                               clk_sys,
  input  wire logic                               rst_n,
  // Control from the page
  input  wire tlc_lane_ctrl_type [`TLC_LANES-1:0] lane_ctrl,
  // Bench commands
  input  wire logic [7:0]                         unlock_req,
  input  wire logic [7:0]                         refuse_req,
  // Status and events back to the page
  output tlc_lane_stat_type [`TLC_LANES-1:0]      lane_stat,
  output tlc_lane_evt_type [`TLC_LANES-1:0]       lane_evt
);
  tlc_lane_ctrl_type [`TLC_LANES-1:0] last_ctrl;
  logic [`TLC_LANES-1:0][3:0]         settle;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_ctrl <= '0;
      settle    <= '0;
    end else begin
      last_ctrl <= lane_ctrl;
      for (int k = 0; k < `TLC_LANES; k++) begin
        // Grid alone does not move the laser
        if ({lane_ctrl[k].channel, lane_ctrl[k].fine, lane_ctrl[k].power} !=
            {last_ctrl[k].channel, last_ctrl[k].fine, last_ctrl[k].power}) begin
          settle[k] <= 4'(SETTLE);
        end else if (settle[k] != 4'h0) begin
          settle[k] <= settle[k] - 4'h1;
        end
      end
    end
  end

  always_comb begin
    for (int k = 0; k < `TLC_LANES; k++) begin
      lane_stat[k].frequency = {lane_ctrl[k].channel, lane_ctrl[k].fine};
      lane_stat[k].active    = (settle[k] != 4'h0);
      lane_stat[k].unlocked  = unlock_req[k];
      lane_evt[k].done       = (settle[k] == 4'h1);
      lane_evt[k].refused    = refuse_req[k];
    end
  end
endmodule

/* File: verification/tlc_page_test.sv */
// Purpose: Self-checking bench for the tuning register page
// Assumes: Inputs change on the falling edge; one read or write at a time
// Notes:   Flag reads clear, so each flag byte is read only where expected
`timescale 1ns/100ps
`include "tlc_map.svh"
module tlc_page_test;
  import tlc_pkg::*;
  logic                               clk_sys;
  logic                               rst_n;
  logic [7:0]                         reg_addr;
  logic                               reg_wr;
  logic                               reg_rd;
  logic [7:0]                         reg_wdata;
  logic [7:0]                         reg_rdata;
  logic                               reg_rvalid;
  tlc_lane_ctrl_type [`TLC_LANES-1:0] lane_ctrl;
  tlc_lane_stat_type [`TLC_LANES-1:0] lane_stat;
  tlc_lane_evt_type [`TLC_LANES-1:0]  lane_evt;
  logic                               irq_req;
  logic                               page_present;
  logic [7:0]                         unlock_req;
  logic [7:0]                         refuse_req;
  int                                 fail_count = 0;
  int                                 tests_run = 0;
  int                                 cycles = 0;
  logic [7:0]                         rd;
  // Range table: field base, word, expected flag byte
  logic [7:0]  ob [5] = '{`TLC_CHAN_BASE, `TLC_FINE_BASE, `TLC_FINE_BASE,
                          `TLC_POWER_BASE, `TLC_POWER_BASE};
  logic [15:0] ov [5] = '{16'h00C8, 16'h1770, 16'h1388, 16'h0258, 16'hFC17};
  logic [7:0]  of [5] = '{8'h05, 8'h11, 8'h01, 8'h21, 8'h21};

  tlc_page dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lane_ctrl(lane_ctrl),
    .lane_stat(lane_stat), .lane_evt(lane_evt), .irq_req(irq_req),
    .page_present(page_present));

  tlc_laser_model laser_u (.clk_sys(clk_sys), .rst_n(rst_n),
    .lane_ctrl(lane_ctrl), .unlock_req(unlock_req), .refuse_req(refuse_req),
    .lane_stat(lane_stat), .lane_evt(lane_evt));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard, well above the few hundred cycles needed
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] ad(input logic [7:0] base, input int k,
                                    input int sz);
    return base + 8'(k * sz);
  endfunction

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  // Answer is flagged valid for the one cycle after the read edge
  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    check(reg_rvalid, 32'h1);
    check(reg_rdata, exp);
  endtask

  // High byte first: range checks run on the low byte
  task automatic write_word(input logic [7:0] a, input logic [15:0] w);
    reg_write(a, w[15:8]);
    reg_write(a + 8'h01, w[7:0]);
  endtask

  initial begin
    rst_n      = 1'b0;
    reg_addr   = 8'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_wdata  = 8'h00;
    unlock_req = 8'h00;
    refuse_req = 8'h00;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    check(page_present, 32'h1);
    check(irq_req, 32'h0);
    for (int k = 0; k < `TLC_LANES; k++) begin
      read_check(ad(`TLC_GRID_BASE, k, 1), 8'hF0);
      read_check(ad(`TLC_MASK_BASE, k, 1), 8'h3F);
      read_check(ad(`TLC_FLAG_BASE, k, 1), 8'h00);
    end
    read_check(`TLC_SUMM_ADDR, 8'h00);
    // Reserved bytes ignore writes and read zero
    for (int i = 0; i < 15; i++) begin
      rd = (i < 6) ? ad(`TLC_RSVA_BASE, i, 1) : ad(`TLC_RSVB_BASE, i - 6, 1);
      reg_write(rd, 8'hA5);
      read_check(rd, 8'h00);
    end
    // Every grid code; reserved bits 3-1 read zero
    for (int c = 0; c < 16; c++) begin
      reg_write(`TLC_GRID_BASE, {4'(c), 4'hF});
      read_check(`TLC_GRID_BASE, {4'(c), 4'h1});
      check(lane_ctrl[0].grid, 32'(c));
      check(lane_ctrl[0].fine_en, 32'h1);
    end
    reg_write(ad(`TLC_GRID_BASE, 7, 1), 8'h50);
    check({lane_ctrl[7].grid, lane_ctrl[7].fine_en}, 32'h0A);
    // Channel word on lane 6 starts a tune, then completes
    write_word(ad(`TLC_CHAN_BASE, 5, 2), 16'hFFF6);
    check(lane_ctrl[5].channel, 32'h0000FFF6);
    read_check(ad(`TLC_STAT_BASE, 5, 1), 8'h02);
    repeat (10) @(negedge clk_sys);
    read_check(ad(`TLC_STAT_BASE, 5, 1), 8'h00);
    read_check(`TLC_SUMM_ADDR, 8'h20);
    read_check(ad(`TLC_FLAG_BASE, 5, 1), 8'h01);
    read_check(ad(`TLC_FLAG_BASE, 5, 1), 8'h00);
    read_check(`TLC_SUMM_ADDR, 8'h00);
    read_check(ad(`TLC_CHAN_BASE, 5, 2), 8'hFF);
    read_check(ad(`TLC_CHAN_BASE, 5, 2) + 8'h01, 8'hF6);
    reg_write(ad(`TLC_FREQ_BASE, 5, 4), 8'h12);
    read_check(ad(`TLC_FREQ_BASE, 5, 4), 8'hFF);
    read_check(ad(`TLC_FREQ_BASE, 5, 4) + 8'h01, 8'hF6);
    read_check(ad(`TLC_FREQ_BASE, 5, 4) + 8'h02, 8'h00);
    // Range errors and the in-range fine boundary on lane 1
    for (int i = 0; i < 5; i++) begin
      write_word(ad(ob[i], 0, 2), ov[i]);
      read_check(`TLC_STAT_BASE, 8'h02);
      repeat (10) @(negedge clk_sys);
      read_check(`TLC_FLAG_BASE, of[i]);
    end
    check(lane_ctrl[0].power, 32'h0000FC17);
    // Unmasked completion raises the request until the flag is read
    reg_write(ad(`TLC_MASK_BASE, 1, 1), 8'hFE);
    read_check(ad(`TLC_MASK_BASE, 1, 1), 8'h3E);
    check(irq_req, 32'h0);
    write_word(ad(`TLC_POWER_BASE, 1, 2), 16'h0064);
    repeat (10) @(negedge clk_sys);
    check(irq_req, 32'h1);
    read_check(`TLC_SUMM_ADDR, 8'h02);
    read_check(ad(`TLC_FLAG_BASE, 1, 1), 8'h01);
    check(irq_req, 32'h0);
    // Unlock is sticky after the cause goes away
    unlock_req = 8'h10;
    repeat (3) @(negedge clk_sys);
    read_check(ad(`TLC_STAT_BASE, 4, 1), 8'h01);
    unlock_req = 8'h00;
    repeat (2) @(negedge clk_sys);
    read_check(ad(`TLC_FLAG_BASE, 4, 1), 8'h02);
    read_check(ad(`TLC_FLAG_BASE, 4, 1), 8'h00);
    // Refusal latches and is cleared by reprogramming the grid
    refuse_req = 8'h40;
    @(negedge clk_sys);
    refuse_req = 8'h00;
    repeat (2) @(negedge clk_sys);
    read_check(`TLC_SUMM_ADDR, 8'h40);
    reg_write(ad(`TLC_GRID_BASE, 6, 1), 8'h40);
    read_check(ad(`TLC_FLAG_BASE, 6, 1), 8'h00);
    test_done();
  end
endmodule
